// ===== inc/stca_pkg.sv
// Package with operation codes, flag layout and reset values for the subtract/test/compare ALU.
package stca_pkg;

  localparam int unsigned STCA_DATA_WIDTH = 8;
  localparam int unsigned STCA_REG_COUNT  = 16;
  localparam int unsigned STCA_REG_ADDR_W = 4;
  localparam int unsigned STCA_BANK_COUNT = 2;

  localparam logic [7:0] STCA_REG_RESET  = 8'h00;
  localparam logic       STCA_FLAG_RESET = 1'b0;

  typedef enum logic [2:0] {
    STCA_OP_MINUS,
    STCA_OP_CHAINED_MINUS,
    STCA_OP_MASK_TEST,
    STCA_OP_CHAINED_MASK_CHECK,
    STCA_OP_COMPARE
  } stca_op_e;

  // One instruction as presented by the decoder.
  typedef struct packed {
    logic       valid;
    stca_op_e   op;
    logic       use_immediate;
    logic [3:0] dest_register;
    logic [3:0] source_register;
    logic [7:0] immediate_byte;
  } stca_cmd_s;

  // Shared flag pair.
  typedef struct packed {
    logic equal_result_flag;
    logic borrow_parity_flag;
  } stca_flags_s;

  // Result of the combinational datapath.
  typedef struct packed {
    logic [7:0]  value;
    logic        write_back;
    stca_flags_s flags;
  } stca_result_s;

  // Register bank write port used by the decoder side.
  typedef struct packed {
    logic       enable;
    logic       bank;
    logic [3:0] index;
    logic [7:0] data;
  } stca_load_s;

endpackage

// ===== hw/stca_operand_mux.sv
// Second operand selection between an immediate byte and a source register.
`timescale 1ns/1ns
module stca_operand_mux #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             i_use_immediate,
  input  wire logic [WIDTH-1:0] i_immediate_byte,
  input  wire logic [WIDTH-1:0] i_register_value,
  output logic      [WIDTH-1:0] o_operand
);

  initial begin
    if (WIDTH < 1) begin
      $error("stca_operand_mux: WIDTH must be at least 1");
    end
  end

  assign o_operand = i_use_immediate ? i_immediate_byte : i_register_value;

endmodule // stca_operand_mux

// ===== hw/stca_alu_core.sv
// Combinational subtract, mask test and compare datapath with flag generation.
`timescale 1ns/1ns
module stca_alu_core
  import stca_pkg::*;
(
  input  wire stca_pkg::stca_op_e     i_op,
  input  wire logic [7:0]             i_dest_value,
  input  wire logic [7:0]             i_operand,
  input  wire stca_pkg::stca_flags_s  i_flags,
  output stca_pkg::stca_result_s      o_result
);

  logic [8:0] diff;
  logic [7:0] masked;
  logic       borrow_in;

  always_comb begin
    borrow_in = (i_op == STCA_OP_CHAINED_MINUS) ? i_flags.borrow_parity_flag : 1'b0;
    // The ninth bit of the wide difference is the borrow out.
    diff      = {1'b0, i_dest_value} - {1'b0, i_operand} - {8'h00, borrow_in};
    masked    = i_dest_value & i_operand;
    o_result  = '0;
    case (i_op)
      STCA_OP_MINUS: begin
        o_result.value                    = diff[7:0];
        o_result.write_back               = 1'b1;
        o_result.flags.equal_result_flag  = (diff[7:0] == 8'h00);
        o_result.flags.borrow_parity_flag = diff[8];
      end
      STCA_OP_CHAINED_MINUS: begin
        o_result.value                    = diff[7:0];
        o_result.write_back               = 1'b1;
        o_result.flags.equal_result_flag  = (diff[7:0] == 8'h00) && i_flags.equal_result_flag;
        o_result.flags.borrow_parity_flag = diff[8];
      end
      STCA_OP_MASK_TEST: begin
        o_result.value                    = i_dest_value;
        o_result.write_back               = 1'b0;
        o_result.flags.equal_result_flag  = (masked == 8'h00);
        o_result.flags.borrow_parity_flag = ^masked;
      end
      STCA_OP_CHAINED_MASK_CHECK: begin
        o_result.value                    = i_dest_value;
        o_result.write_back               = 1'b0;
        o_result.flags.equal_result_flag  = (masked == 8'h00) && i_flags.equal_result_flag;
        o_result.flags.borrow_parity_flag = (^masked) ^ i_flags.borrow_parity_flag;
      end
      STCA_OP_COMPARE: begin
        o_result.value                    = i_dest_value;
        o_result.write_back               = 1'b0;
        o_result.flags.equal_result_flag  = (diff[7:0] == 8'h00);
        o_result.flags.borrow_parity_flag = diff[8];
      end
      default: begin
        o_result.value = i_dest_value;
        o_result.flags = i_flags;
      end
    endcase
  end

endmodule // stca_alu_core

// ===== hw/stca_subtract_test_compare_alu.sv
// Top of the subtract/test/compare ALU slice with its register bank and shared flags.
//
// Operation
// - Plain subtract writes destination minus operand back into destination.
// - Plain subtract sets equal flag when written difference is zero.
// - Plain subtract sets borrow flag when the difference is negative.
// - Chained minus also subtracts incoming borrow, writes back, sets borrow.
// - Chained minus sets equal flag only if result zero and flag was set.
// - Mask test ANDs operands, keeps destination, updates only flags.
// - Mask test sets equal flag when the AND result is all zero.
// - Mask test sets borrow flag to XOR of the AND result bits.
// - Chained mask check keeps destination; equal flag needs zero and prior set.
// - Chained mask check parity covers AND bits plus previous borrow flag.
// - Compare subtracts into discarded temporary, keeps destination, updates flags.
// - Compare sets equal flag when operands match.
// - Compare sets borrow flag when destination is below operand.
// - Second operand is an immediate byte or a source register.
// - Registers are chosen from the sixteen of the active bank.
`timescale 1ns/1ns
module stca_subtract_test_compare_alu
  import stca_pkg::*;
#(
  parameter int unsigned REG_COUNT  = STCA_REG_COUNT,
  parameter int unsigned BANK_COUNT = STCA_BANK_COUNT
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_reset_n,
  input  wire stca_pkg::stca_cmd_s   i_cmd,
  input  wire logic                  i_bank_select,
  input  wire stca_pkg::stca_load_s  i_load,
  input  wire logic [3:0]            i_peek_index,
  output stca_pkg::stca_flags_s      o_flags,
  output logic [7:0]                 o_result,
  output logic                       o_result_valid,
  output logic [7:0]                 o_peek_data
);
  import stca_pkg::*;

  initial begin
    if (REG_COUNT != STCA_REG_COUNT || BANK_COUNT != STCA_BANK_COUNT) begin
      $error("stca_subtract_test_compare_alu: only 2 banks of 16 registers are served");
    end
  end

  // Whole module state in one struct, registered in one process.
  typedef struct packed {
    logic [1:0][15:0][7:0] bank_regs;
    stca_flags_s           flags;
    logic                  active_bank;
    logic [7:0]            result;
    logic                  result_valid;
    logic [7:0]            peek;
  } stca_state_s;

  stca_state_s  state;
  stca_state_s  next_state;
  logic [7:0]   dest_value;
  logic [7:0]   source_value;
  logic [7:0]   operand;
  stca_result_s alu_out;

  // Operands are read from the bank that is active when the command arrives.
  assign dest_value   = state.bank_regs[state.active_bank][i_cmd.dest_register];
  assign source_value = state.bank_regs[state.active_bank][i_cmd.source_register];

  stca_operand_mux #(
    .WIDTH (STCA_DATA_WIDTH)
  ) u_operand_mux (
    .i_use_immediate  (i_cmd.use_immediate),
    .i_immediate_byte (i_cmd.immediate_byte),
    .i_register_value (source_value),
    .o_operand        (operand)
  );

  stca_alu_core u_alu_core (
    .i_op         (i_cmd.op),
    .i_dest_value (dest_value),
    .i_operand    (operand),
    .i_flags      (state.flags),
    .o_result     (alu_out)
  );

  always_comb begin
    next_state              = state;
    next_state.result_valid = 1'b0;
    next_state.active_bank  = i_bank_select;
    next_state.peek         = state.bank_regs[state.active_bank][i_peek_index];
    // A decoder load lands first so an ALU write to the same register in
    // the same cycle wins, matching instruction order.
    if (i_load.enable) begin
      next_state.bank_regs[i_load.bank][i_load.index] = i_load.data;
    end
    if (i_cmd.valid) begin
      next_state.flags        = alu_out.flags;
      next_state.result       = alu_out.value;
      next_state.result_valid = 1'b1;
      if (alu_out.write_back) begin
        next_state.bank_regs[state.active_bank][i_cmd.dest_register] = alu_out.value;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_flags        = state.flags;
  assign o_result       = state.result;
  assign o_result_valid = state.result_valid;
  assign o_peek_data    = state.peek;

endmodule // stca_subtract_test_compare_alu

// ===== testbench/stca_alu_assertions.sv
// Checker of result timing and flag behaviour at the ALU slice's ports.
`timescale 1ns/1ns
module stca_alu_assertions
  import stca_pkg::*;
(
  input wire logic                  i_clock,
  input wire logic                  i_reset_n,
  input wire stca_pkg::stca_cmd_s   i_cmd,
  input wire stca_pkg::stca_flags_s o_flags,
  input wire logic [7:0]            o_result,
  input wire logic                  o_result_valid
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  wire v = i_cmd.valid;
  wire k0 = i_cmd.use_immediate && i_cmd.immediate_byte == 8'h00;
  wire z = o_flags.equal_result_flag;
  wire c = o_flags.borrow_parity_flag;
  chk_pulse_on: assert property (v |=> o_result_valid) else $error("no result pulse");
  chk_pulse_off: assert property (!v |=> !o_result_valid) else $error("stray pulse");
  chk_flags_hold: assert property (!v |=> $stable(o_flags)) else $error("flags moved");
  chk_sub_zero: assert property (v && i_cmd.op == STCA_OP_MINUS
    |=> z == (o_result == 8'h00)) else $error("zero flag wrong after subtract");
  chk_sub_noborrow: assert property (v && i_cmd.op == STCA_OP_MINUS && k0 |=> !c)
    else $error("borrow on zero subtrahend");
  chk_chain_zero: assert property (v && i_cmd.op == STCA_OP_CHAINED_MINUS && !z |=> !z)
    else $error("chained zero flag rose");
  chk_mask_zero: assert property (v && i_cmd.op == STCA_OP_MASK_TEST && k0 |=> z && !c)
    else $error("empty mask flags wrong");
  chk_mchk_zero: assert property (v && i_cmd.op == STCA_OP_CHAINED_MASK_CHECK && !z |=> !z)
    else $error("chained mask zero flag rose");
  chk_cmp_top: assert property (v && i_cmd.op == STCA_OP_COMPARE && i_cmd.use_immediate
    && i_cmd.immediate_byte == 8'hFF |=> z || c) else $error("compare with top value wrong");
endmodule // stca_alu_assertions

bind stca_subtract_test_compare_alu stca_alu_assertions i_chk (.i_clock(i_clock),
  .i_reset_n(i_reset_n), .i_cmd(i_cmd), .o_flags(o_flags), .o_result(o_result),
  .o_result_valid(o_result_valid));

// ===== testbench/stca_decoder_model.sv
// Decoder and register loader model driving the ALU slice's command side.
`timescale 1ns/1ns
module stca_decoder_model
  import stca_pkg::*;
(
  input  wire logic           i_clock,
  output stca_pkg::stca_cmd_s  o_cmd,
  output stca_pkg::stca_load_s o_load
);
  initial begin
    o_cmd = '0;
    o_load = '0;
  end
  task automatic issue(input stca_op_e op, input logic [3:0] d, s, input logic imm,
                       input logic [7:0] k);
    @(posedge i_clock) #1;
    o_cmd <= '{1'b1, op, imm, d, s, k};
    @(posedge i_clock) #1;
    // Released fields are scrambled so a stale operand cannot pass by chance.
    o_cmd <= '{1'b0, op, ~imm, ~d, ~s, ~k};
  endtask
  task automatic put(input logic b, input logic [3:0] i, input logic [7:0] v);
    @(posedge i_clock) #1;
    o_load <= '{1'b1, b, i, v};
    @(posedge i_clock) #1;
    o_load <= '{1'b0, ~b, ~i, ~v};
  endtask
endmodule // stca_decoder_model

// ===== testbench/tb_top.sv
// Self-checking bench for the subtract/test/compare ALU slice.
`timescale 1ns/1ns
module tb_top;
  import stca_pkg::*;
  logic        i_clock;
  logic        i_reset_n;
  logic        i_bank_select;
  logic [3:0]  i_peek_index;
  stca_cmd_s   cmd;
  stca_load_s  load;
  stca_flags_s o_flags;
  logic [7:0]  o_result;
  logic [7:0]  o_peek_data;
  logic        o_result_valid;
  logic [7:0]  rf [2][16];
  logic        bk;
  logic        fz;
  logic        fc;
  int          errors;
  int          n_checks;
  int          cyc;
  stca_decoder_model i_stca_decoder_model (.i_clock(i_clock), .o_cmd(cmd), .o_load(load));
  stca_subtract_test_compare_alu i_stca_subtract_test_compare_alu (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_cmd(cmd), .i_bank_select(i_bank_select), .i_load(load),
    .i_peek_index(i_peek_index), .o_flags(o_flags), .o_result(o_result),
    .o_result_valid(o_result_valid), .o_peek_data(o_peek_data));
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 1000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ld(input logic b, input logic [3:0] i, input logic [7:0] v);
    i_stca_decoder_model.put(b, i, v);
    rf[b][i] = v;
  endtask
  // Expected flags chain from the previous operation, as multi-byte code relies on.
  task automatic run(input stca_op_e op, input logic [3:0] d, s, input logic imm,
                     input logic [7:0] k);
    logic [7:0] a;
    logic [8:0] t;
    a = rf[bk][d] & (imm ? k : rf[bk][s]);
    t = {1'b0, rf[bk][d]} - {1'b0, imm ? k : rf[bk][s]};
    t = t - {8'h00, fc && op == STCA_OP_CHAINED_MINUS};
    i_stca_decoder_model.issue(op, d, s, imm, k);
    chk({7'h00, o_result_valid}, 8'h01);
    if (op == STCA_OP_MINUS || op == STCA_OP_CHAINED_MINUS) begin
      fz = t[7:0] == 8'h00 && (fz || op == STCA_OP_MINUS);
      fc = t[8];
      rf[bk][d] = t[7:0];
      chk(o_result, t[7:0]);
    end else if (op == STCA_OP_COMPARE) begin
      chk(o_result, rf[bk][d]);
      fz = t[7:0] == 8'h00;
      fc = t[8];
    end else begin
      chk(o_result, rf[bk][d]);
      fz = a == 8'h00 && (fz || op == STCA_OP_MASK_TEST);
      fc = ^a ^ (fc && op == STCA_OP_CHAINED_MASK_CHECK);
    end
    chk({6'h00, o_flags}, {6'h00, fz, fc});
    i_peek_index = d;
    @(posedge i_clock) #1;
    chk(o_peek_data, rf[bk][d]);
    chk({7'h00, o_result_valid}, 8'h00);
  endtask
  task automatic t_sub();
    ld(0, 1, 8'h7B);
    ld(0, 2, 8'hA2);
    ld(0, 3, 8'hA1);
    run(STCA_OP_MINUS, 1, 0, 1, 8'hB9);
    run(STCA_OP_CHAINED_MINUS, 2, 3, 0, 8'h00);
    run(STCA_OP_MINUS, 1, 0, 1, 8'h00);
    run(STCA_OP_MINUS, 1, 1, 0, 8'h00);
    run(STCA_OP_CHAINED_MINUS, 2, 2, 0, 8'h00);
    $display("subtract test done");
  endtask
  task automatic t_mask();
    ld(0, 5, 8'hCA);
    ld(0, 6, 8'h52);
    run(STCA_OP_MASK_TEST, 5, 0, 1, 8'hFF);
    run(STCA_OP_CHAINED_MASK_CHECK, 6, 0, 1, 8'hFF);
    run(STCA_OP_MASK_TEST, 5, 0, 1, 8'h04);
    run(STCA_OP_CHAINED_MASK_CHECK, 6, 0, 1, 8'h20);
    run(STCA_OP_MASK_TEST, 5, 0, 1, 8'h00);
    run(STCA_OP_MASK_TEST, 5, 6, 0, 8'h00);
    $display("mask test done");
  endtask
  task automatic t_cmp();
    run(STCA_OP_COMPARE, 5, 0, 1, 8'hCA);
    run(STCA_OP_COMPARE, 5, 0, 1, 8'hFF);
    run(STCA_OP_COMPARE, 5, 6, 0, 8'h00);
    repeat (3) @(posedge i_clock);
    #1;
    chk({6'h00, o_flags}, {6'h00, fz, fc});
    $display("compare test done");
  endtask
  task automatic t_bank();
    i_bank_select = 1'b1;
    bk = 1'b1;
    ld(1, 1, 8'h10);
    run(STCA_OP_MINUS, 1, 0, 1, 8'h10);
    i_bank_select = 1'b0;
    bk = 1'b0;
    @(posedge i_clock) #1;
    run(STCA_OP_COMPARE, 1, 0, 1, 8'hC2);
    $display("bank test done");
  endtask
  initial begin
    i_reset_n = 1'b0;
    i_bank_select = 1'b0;
    i_peek_index = 4'h0;
    rf = '{default: 8'h00};
    {bk, fz, fc} = 3'h0;
    repeat (2) @(posedge i_clock);
    #1 i_reset_n = 1'b1;
    chk({6'h00, o_flags}, 8'h00);
    t_sub();
    t_mask();
    t_cmp();
    t_bank();
    wrap_up();
  end
endmodule // tb_top
